// ==== acs_pkg.sv ====
// constants, types and the microsecond timer for the conversion sequencer
package acs_pkg;
    localparam int unsigned ADC_W        = 10;
    localparam int unsigned ACC_W        = 18;
    localparam int unsigned FAULT_W      = 16;
    localparam int unsigned US_W         = 16;
    localparam int unsigned CLK_HZ       = 25_000_000;
    localparam int unsigned US_HZ        = 1_000_000;
    localparam logic [4:0]  TICK_CYCLES  = 5'(CLK_HZ / US_HZ);

    // wait between conversions, in microseconds, 0 ms up to 20.48 ms
    localparam logic [US_W-1:0] WAIT_US_0  = 16'h0000;
    localparam logic [US_W-1:0] WAIT_US_1  = 16'h000A;
    localparam logic [US_W-1:0] WAIT_US_2  = 16'h0014;
    localparam logic [US_W-1:0] WAIT_US_3  = 16'h0028;
    localparam logic [US_W-1:0] WAIT_US_4  = 16'h0050;
    localparam logic [US_W-1:0] WAIT_US_5  = 16'h00A0;
    localparam logic [US_W-1:0] WAIT_US_6  = 16'h0140;
    localparam logic [US_W-1:0] WAIT_US_7  = 16'h0280;
    localparam logic [US_W-1:0] WAIT_US_8  = 16'h0500;
    localparam logic [US_W-1:0] WAIT_US_9  = 16'h0A00;
    localparam logic [US_W-1:0] WAIT_US_10 = 16'h1400;
    localparam logic [US_W-1:0] WAIT_US_11 = 16'h1E00;
    localparam logic [US_W-1:0] WAIT_US_12 = 16'h2800;
    localparam logic [US_W-1:0] WAIT_US_13 = 16'h3200;
    localparam logic [US_W-1:0] WAIT_US_14 = 16'h3C00;
    localparam logic [US_W-1:0] WAIT_US_15 = 16'h5000;

    // delay between runs in repeat mode, in microseconds
    localparam logic [US_W-1:0] DELAY_US_0 = 16'h03E8;
    localparam logic [US_W-1:0] DELAY_US_1 = 16'h1388;
    localparam logic [US_W-1:0] DELAY_US_2 = 16'h2710;
    localparam logic [US_W-1:0] DELAY_US_3 = 16'hC350;

    // sample count shift per 3-bit code: 1,2,4,8,16,32,64,256
    localparam logic [3:0] SHIFT_7 = 4'h8;

    typedef struct packed {
        logic             repeat_mode;
        logic [1:0]       delay_sel;
        logic             ext_trig_en;
        logic             trig_rising;
        logic             holdoff_en;
        logic [2:0]       channel;
        logic [2:0]       samples_sel;
        logic [3:0]       wait_sel;
        logic             ref_ext;
        logic [1:0]       current_sel;
    } acs_cfg_t;

    typedef struct packed {
        logic [ADC_W-1:0] average;
        logic [ADC_W-1:0] last;
        logic [ADC_W-1:0] minimum;
        logic [ADC_W-1:0] maximum;
    } acs_result_t;

    typedef struct packed {
        logic done;
        logic high;
        logic low;
    } acs_ack_t;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_CONV  = 5'h02,
        ST_WAIT  = 5'h04,
        ST_FIN   = 5'h08,
        ST_DELAY = 5'h10
    } acs_state_t;

    function automatic logic [US_W-1:0] acs_wait_us(input logic [3:0] sel);
        logic [US_W-1:0] v;
        case (sel)
            4'h0: v = WAIT_US_0;
            4'h1: v = WAIT_US_1;
            4'h2: v = WAIT_US_2;
            4'h3: v = WAIT_US_3;
            4'h4: v = WAIT_US_4;
            4'h5: v = WAIT_US_5;
            4'h6: v = WAIT_US_6;
            4'h7: v = WAIT_US_7;
            4'h8: v = WAIT_US_8;
            4'h9: v = WAIT_US_9;
            4'hA: v = WAIT_US_10;
            4'hB: v = WAIT_US_11;
            4'hC: v = WAIT_US_12;
            4'hD: v = WAIT_US_13;
            4'hE: v = WAIT_US_14;
            default: v = WAIT_US_15;
        endcase
        return v;
    endfunction : acs_wait_us

    function automatic logic [US_W-1:0] acs_delay_us(input logic [1:0] sel);
        logic [US_W-1:0] v;
        case (sel)
            2'h0: v = DELAY_US_0;
            2'h1: v = DELAY_US_1;
            2'h2: v = DELAY_US_2;
            default: v = DELAY_US_3;
        endcase
        return v;
    endfunction : acs_delay_us

    function automatic logic [3:0] acs_shift(input logic [2:0] sel);
        logic [3:0] v;
        v = (sel == 3'h7) ? SHIFT_7 : {1'b0, sel};
        return v;
    endfunction : acs_shift
endpackage : acs_pkg

`timescale 1ns/1ps
module acs_timer (
    input  wire logic                    sys_clk,
    input  wire logic                    rstn,
    input  wire logic                    load,
    input  wire logic [acs_pkg::US_W-1:0] load_us,
    output logic                         expired
);
    import acs_pkg::*;

    logic [4:0]      pre;
    logic [US_W-1:0] remain;
    wire             tick = (pre == TICK_CYCLES - 5'h01);

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            pre    <= 5'h00;
            remain <= 16'h0000;
        end else if (load) begin
            pre    <= 5'h00;
            remain <= load_us;
        end else begin
            pre <= tick ? 5'h00 : pre + 5'h01;
            if (tick && remain != 16'h0000) begin
                remain <= remain - 16'h0001;
            end
        end
    end

    assign expired = (remain == 16'h0000) && !load;
endmodule : acs_timer

// ==== acs_sequencer.sv ====
// conversion sequencer: run control, triggering, averaging, alarms, fault pulses
//
// Overview of operation
// - single run or continuous repeated runs
// - stop command ends repeat mode conversions
// - two-bit delay between runs in repeat
// - trigger input edge starts when enabled
// - trigger edge polarity selectable rising/falling
// - hold-off pauses collection at inactive level
// - three-bit selector picks one of eight channels
// - sample count code gives 1 to 256
// - four-bit wait between conversions, 0-20.48ms
// - threshold crossing stops run, reports which
// - exactly one acknowledgement flag per stop
// - uncollected samples count as zero in average
// - stop finishes conversion in progress first
// - four result readings published on completion
// - two-bit excitation current source select
// - reference select internal or external
// - unmasked fault signals pulse interrupt output
// - done only without alarm violation
// - acknowledgement flags clear on host read
`timescale 1ns/1ps
module acs_sequencer (
    input  wire logic                          sys_clk,
    input  wire logic                          rstn,
    input  wire acs_pkg::acs_cfg_t             cfg,
    input  wire logic                          start_cmd,
    input  wire logic                          stop_cmd,
    input  wire logic [acs_pkg::ADC_W-1:0]     high_alarm_threshold,
    input  wire logic [acs_pkg::ADC_W-1:0]     low_alarm_threshold,
    input  wire logic                          general_input_three,
    input  wire logic                          conv_ack,
    input  wire logic [acs_pkg::ADC_W-1:0]     conv_data,
    input  wire logic                          ack_read,
    input  wire logic [acs_pkg::FAULT_W-1:0]   fault_in,
    input  wire logic [acs_pkg::FAULT_W-1:0]   fault_mask,
    output logic                               conv_req,
    output logic [2:0]                         conv_channel,
    output logic                               conv_ref_ext,
    output logic [1:0]                         conv_current_sel,
    output logic                               busy,
    output acs_pkg::acs_result_t               result,
    output acs_pkg::acs_ack_t                  ack,
    output logic                               int_pulse
);
    import acs_pkg::*;

    acs_state_t       state;
    acs_state_t       next_state;
    logic             trig_prev;
    logic             stop_pend;
    logic [8:0]       count;
    logic [ACC_W-1:0] acc;
    logic [ADC_W-1:0] last;
    logic [ADC_W-1:0] min_v;
    logic [ADC_W-1:0] max_v;
    logic [FAULT_W-1:0] fault_prev;
    logic             tmr_load;
    logic [US_W-1:0]  tmr_us;
    logic             tmr_expired;

    // trigger level seen through the selected polarity
    wire trig_active = cfg.trig_rising ? general_input_three
                                       : !general_input_three;
    wire trig_edge   = trig_active && !trig_prev;
    wire run_start   = cfg.ext_trig_en ? trig_edge : start_cmd;
    wire held        = cfg.holdoff_en && !trig_active;

    // sample count and averaging shift
    wire [3:0] shift     = acs_shift(cfg.samples_sel);
    wire [8:0] target    = 9'(9'h001 << shift);
    wire       sample_in = (state == ST_CONV) && conv_req && conv_ack;
    wire       over_high = conv_data > high_alarm_threshold;
    wire       under_low = conv_data < low_alarm_threshold;
    wire       alarm     = sample_in && (over_high || under_low);
    wire       good_in   = sample_in && !alarm;
    wire       last_one  = (count + 9'h001) == target;
    wire       stop_now  = stop_pend || (stop_cmd && cfg.repeat_mode);

    // sum of the collected samples; missing slots add nothing
    wire [ACC_W-1:0] acc_sum  = acc + ACC_W'(conv_data);
    wire [ACC_W-1:0] acc_fin  = good_in ? acc_sum : acc;
    wire [ACC_W-1:0] avg_full = acc_fin >> shift;
    wire [ADC_W-1:0] avg      = avg_full[ADC_W-1:0];

    wire [ADC_W-1:0] min_fin  = (good_in && conv_data < min_v) ? conv_data : min_v;
    wire [ADC_W-1:0] max_fin  = (good_in && conv_data > max_v) ? conv_data : max_v;
    wire [ADC_W-1:0] last_fin = sample_in ? conv_data : last;

    // result is published on a finished run, a stop, or an alarm
    wire publish = (state == ST_FIN)
                || alarm
                || (state == ST_WAIT && stop_now)
                || (state == ST_DELAY && stop_now);

    // flag events; each stop raises exactly one
    wire set_high = alarm && over_high;
    wire set_low  = alarm && !over_high;
    wire set_done = !alarm && publish && (!cfg.repeat_mode || stop_now);

    // fault detection: a new unmasked fault pulses the interrupt
    wire [FAULT_W-1:0] fault_rise = fault_in & ~fault_prev & ~fault_mask;

    always_comb begin
        next_state = state;
        tmr_load   = 1'b0;
        tmr_us     = acs_wait_us(cfg.wait_sel);
        case (state)
            ST_IDLE: begin
                if (run_start) begin
                    next_state = ST_CONV;
                end
            end
            ST_CONV: begin
                if (alarm) begin
                    next_state = ST_IDLE;
                end else if (good_in && last_one) begin
                    next_state = ST_FIN;
                end else if (good_in && stop_now) begin
                    next_state = ST_FIN;
                end else if (good_in) begin
                    next_state = ST_WAIT;
                    tmr_load   = 1'b1;
                end
            end
            ST_WAIT: begin
                if (stop_now) begin
                    next_state = ST_IDLE;
                end else if (tmr_expired) begin
                    next_state = ST_CONV;
                end
            end
            ST_FIN: begin
                if (cfg.repeat_mode && !stop_now) begin
                    next_state = ST_DELAY;
                    tmr_load   = 1'b1;
                    tmr_us     = acs_delay_us(cfg.delay_sel);
                end else begin
                    next_state = ST_IDLE;
                end
            end
            ST_DELAY: begin
                if (stop_now) begin
                    next_state = ST_IDLE;
                end else if (tmr_expired) begin
                    next_state = ST_CONV;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    acs_timer u_timer (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .load    (tmr_load),
        .load_us (tmr_us),
        .expired (tmr_expired)
    );

    wire run_restart = (state == ST_IDLE && run_start)
                    || (state == ST_DELAY && tmr_expired && !stop_now);

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state     <= ST_IDLE;
            // seen as already active, so no false edge follows reset
            trig_prev <= 1'b1;
            stop_pend <= 1'b0;
        end else begin
            state     <= next_state;
            trig_prev <= trig_active;
            if (next_state == ST_IDLE || run_restart) begin
                stop_pend <= 1'b0;
            end else if (stop_cmd && cfg.repeat_mode) begin
                stop_pend <= 1'b1;
            end
        end
    end

    // per-run accumulation
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            count <= 9'h000;
            acc   <= '0;
            last  <= '0;
            min_v <= '1;
            max_v <= '0;
        end else if (run_restart) begin
            count <= 9'h000;
            acc   <= '0;
            min_v <= '1;
            max_v <= '0;
        end else if (sample_in) begin
            last  <= conv_data;
            if (good_in) begin
                count <= count + 9'h001;
                acc   <= acc_sum;
                min_v <= min_fin;
                max_v <= max_fin;
            end
        end
    end

    // converter request and analog selection
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            conv_req         <= 1'b0;
            conv_channel     <= 3'h0;
            conv_ref_ext     <= 1'b0;
            conv_current_sel <= 2'h0;
            busy             <= 1'b0;
        end else begin
            conv_channel     <= cfg.channel;
            conv_ref_ext     <= cfg.ref_ext;
            conv_current_sel <= cfg.current_sel;
            busy             <= (next_state != ST_IDLE);
            if (sample_in || next_state != ST_CONV) begin
                conv_req <= 1'b0;
            end else if (!held) begin
                conv_req <= 1'b1;
            end
        end
    end

    // published readings: average, last, minimum, maximum
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            result <= '0;
        end else if (publish) begin
            result.average <= avg;
            result.last    <= last_fin;
            result.minimum <= (count == 9'h000 && !good_in) ? '0 : min_fin;
            result.maximum <= max_fin;
        end
    end

    // acknowledgement flags; a set in the read cycle survives
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ack <= '0;
        end else begin
            ack.done <= set_done || (ack.done && !ack_read);
            ack.high <= set_high || (ack.high && !ack_read);
            ack.low  <= set_low  || (ack.low  && !ack_read);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            fault_prev <= '0;
            int_pulse  <= 1'b0;
        end else begin
            fault_prev <= fault_in;
            int_pulse  <= |fault_rise;
        end
    end
endmodule : acs_sequencer

// ==== acs_chk_properties.sv ====
// concurrent checks on the conversion sequencer ports
`timescale 1ns/1ps
module acs_chk (
    input wire logic                         sys_clk,
    input wire logic                         rstn,
    input wire acs_pkg::acs_cfg_t            cfg,
    input wire logic                         start_cmd,
    input wire logic [acs_pkg::ADC_W-1:0]    high_alarm_threshold,
    input wire logic [acs_pkg::ADC_W-1:0]    low_alarm_threshold,
    input wire logic                         conv_ack,
    input wire logic [acs_pkg::ADC_W-1:0]    conv_data,
    input wire logic                         ack_read,
    input wire logic [acs_pkg::FAULT_W-1:0]  fault_in,
    input wire logic [acs_pkg::FAULT_W-1:0]  fault_mask,
    input wire logic                         conv_req,
    input wire logic [2:0]                   conv_channel,
    input wire logic                         conv_ref_ext,
    input wire logic [1:0]                   conv_current_sel,
    input wire logic                         busy,
    input wire acs_pkg::acs_result_t         result,
    input wire acs_pkg::acs_ack_t            ack,
    input wire logic                         int_pulse
);
    import acs_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_launch;
        busy ##1 conv_req;
    endsequence
    sequence s_sample;
        conv_req && conv_ack;
    endsequence

    property p_start;
        start_cmd && !busy && !cfg.ext_trig_en && !cfg.holdoff_en |=> s_launch;
    endproperty
    a_start: assert property (p_start) else $error("start did not launch");
    property p_high;
        s_sample and conv_data > high_alarm_threshold |=> ack.high && !ack.done && !ack.low;
    endproperty
    a_high: assert property (p_high) else $error("high alarm missed");
    property p_low;
        s_sample and conv_data < low_alarm_threshold |=> ack.low && !ack.done;
    endproperty
    a_low: assert property (p_low) else $error("low alarm missed");
    property p_one_flag;
        ack != 3'h0 && $past(ack) == 3'h0 |-> $onehot(ack);
    endproperty
    a_one_flag: assert property (p_one_flag) else $error("several flags at once");
    property p_done_clean;
        $rose(ack.done) |-> result.last <= high_alarm_threshold
            && result.last >= low_alarm_threshold;
    endproperty
    a_done_clean: assert property (p_done_clean) else $error("done on alarm value");
    property p_req_hold;
        conv_req && !conv_ack |=> conv_req;
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped early");
    property p_copy;
        $rose(conv_req) |-> conv_channel == $past(cfg.channel)
            && conv_ref_ext == $past(cfg.ref_ext) && conv_current_sel == $past(cfg.current_sel);
    endproperty
    a_copy: assert property (p_copy) else $error("converter setup wrong");
    property p_int;
        (fault_in & ~fault_mask & ~$past(fault_in)) != 16'h0000 |=> int_pulse;
    endproperty
    a_int: assert property (p_int) else $error("fault pulse missing");
    property p_clear;
        ack != 3'h0 && ack_read && !busy |=> ack == 3'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("flags not cleared");
endmodule : acs_chk

bind acs_sequencer acs_chk chk_u (
    .sys_clk(sys_clk), .rstn(rstn), .cfg(cfg), .start_cmd(start_cmd),
    .high_alarm_threshold(high_alarm_threshold), .low_alarm_threshold(low_alarm_threshold),
    .conv_ack(conv_ack), .conv_data(conv_data), .ack_read(ack_read), .fault_in(fault_in),
    .fault_mask(fault_mask), .conv_req(conv_req), .conv_channel(conv_channel),
    .conv_ref_ext(conv_ref_ext), .conv_current_sel(conv_current_sel), .busy(busy),
    .result(result), .ack(ack), .int_pulse(int_pulse)
);

// ==== acs_conv_model.sv ====
// behavioural converter answering sample requests
`timescale 1ns/1ps
module acs_conv_model (
    input  wire logic                      sys_clk,
    input  wire logic                      rstn,
    input  wire logic [7:0]                ack_delay,
    input  wire logic                      conv_req,
    output logic                           conv_ack,
    output logic [acs_pkg::ADC_W-1:0]      conv_data
);
    import acs_pkg::*;
    logic [ADC_W-1:0] fifo[$];
    logic [7:0]       waited;

    task automatic push(input logic [ADC_W-1:0] v);
        fifo.push_back(v);
    endtask : push

    // data toggles outside the ack cycle so a stale sample never looks valid
    always @(posedge sys_clk) begin
        if (!rstn) begin
            conv_ack <= 1'b0;
            conv_data <= '0;
            waited <= 8'h00;
        end else if (!conv_ack && conv_req && waited >= ack_delay) begin
            conv_ack <= 1'b1;
            conv_data <= (fifo.size() > 0) ? fifo.pop_front() : '0;
            waited <= 8'h00;
        end else begin
            conv_ack <= 1'b0;
            conv_data <= ~conv_data;
            waited <= (conv_req && !conv_ack) ? waited + 8'h01 : 8'h00;
        end
    end
endmodule : acs_conv_model

// ==== tb_acs_sequencer.sv ====
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module tb_acs_sequencer;
    import acs_pkg::*;
    logic               sys_clk = 1'b0;
    logic               rstn = 1'b0;
    acs_cfg_t           cfg = '0;
    logic               start_cmd = 1'b0;
    logic               stop_cmd = 1'b0;
    logic [ADC_W-1:0]   high_alarm_threshold = 10'h300;
    logic [ADC_W-1:0]   low_alarm_threshold = 10'h008;
    logic               general_input_three = 1'b0;
    logic               ack_read = 1'b0;
    logic [FAULT_W-1:0] fault_in = 16'h0000;
    logic [FAULT_W-1:0] fault_mask = 16'h0000;
    logic [7:0]         ack_delay = 8'h02;
    logic               conv_ack, conv_req, conv_ref_ext, busy, int_pulse;
    logic [ADC_W-1:0]   conv_data;
    logic [2:0]         conv_channel;
    logic [1:0]         conv_current_sel;
    acs_result_t        result;
    acs_ack_t           ack;
    int                 fails = 0;
    int                 n_compared = 0;

    always #20 sys_clk = ~sys_clk;

    acs_sequencer dut_u (.sys_clk(sys_clk), .rstn(rstn), .cfg(cfg), .start_cmd(start_cmd),
        .stop_cmd(stop_cmd), .high_alarm_threshold(high_alarm_threshold),
        .low_alarm_threshold(low_alarm_threshold), .general_input_three(general_input_three),
        .conv_ack(conv_ack), .conv_data(conv_data), .ack_read(ack_read), .fault_in(fault_in),
        .fault_mask(fault_mask), .conv_req(conv_req), .conv_channel(conv_channel),
        .conv_ref_ext(conv_ref_ext), .conv_current_sel(conv_current_sel), .busy(busy),
        .result(result), .ack(ack), .int_pulse(int_pulse));
    acs_conv_model conv_u (.sys_clk(sys_clk), .rstn(rstn), .ack_delay(ack_delay),
        .conv_req(conv_req), .conv_ack(conv_ack), .conv_data(conv_data));

    function automatic logic pick(input int w);
        return (w == 0) ? busy : (w == 1) ? conv_req : (w == 2) ? conv_ack : int_pulse;
    endfunction : pick

    task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic stop_test;
        if (fails == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test

    // 0 start, 1 stop, 2 flag read; one cycle wide
    task automatic strobe(input int which);
        @(posedge sys_clk);
        start_cmd <= (which == 0);
        stop_cmd <= (which == 1);
        ack_read <= (which == 2);
        @(posedge sys_clk);
        {start_cmd, stop_cmd, ack_read} <= 3'h0;
        @(negedge sys_clk);
    endtask : strobe

    task automatic wait_on(input int w, input logic lvl, input int max, output int n);
        n = 0;
        forever begin
            @(negedge sys_clk);
            if (pick(w) === lvl) break;
            n++;
            if (n >= max) begin
                check("wait bound", 40'h0, 40'h1);
                stop_test();
            end
        end
    endtask : wait_on

    task automatic count_on(input int w, input int len, output int k);
        k = 0;
        repeat (len) begin
            @(negedge sys_clk);
            k += (pick(w) === 1'b1);
        end
    endtask : count_on

    // stop is pulsed on purpose: a single run must ignore it
    task automatic run(input acs_cfg_t c, input logic [ADC_W-1:0] v[$]);
        int n;
        @(posedge sys_clk);
        cfg <= c;
        foreach (v[i]) conv_u.push(v[i]);
        strobe(0);
        strobe(1);
        wait_on(0, 1'b0, 4000, n);
    endtask : run

    initial begin
        acs_cfg_t c;
        int n, k, cnt, sum;
        logic [ADC_W-1:0] q[$];
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        @(negedge sys_clk);
        check("idle flags", ack, 3'h0);
        for (int ch = 0; ch < 8; ch++) begin
            c = '0;
            c.channel = 3'(ch);
            c.ref_ext = ch[0];
            c.current_sel = ch[1:0];
            run(c, '{10'(16 + ch * 64)});
            check("channel", conv_channel, ch);
            check("reference", conv_ref_ext, ch & 1);
            check("current", conv_current_sel, ch & 3);
            check("readings", result, {4{10'(16 + ch * 64)}});
            check("flags", ack, 3'h4);
            strobe(2);
            check("flags", ack, 3'h0);
        end
        for (int s = 0; s < 8; s++) begin
            cnt = (s == 7) ? 256 : (1 << s);
            sum = 0;
            q = {};
            for (int i = 0; i < cnt; i++) begin
                q.push_back(10'(16 + (i % 64) * 4));
                sum += 16 + (i % 64) * 4;
            end
            c = '0;
            c.samples_sel = 3'(s);
            run(c, q);
            check("average", result.average, sum / cnt);
            check("minimum", result.minimum, 16);
            check("maximum", result.maximum, (cnt > 64) ? 268 : 12 + cnt * 4);
            strobe(2);
        end
        // moved thresholds: values between old and new limits must trip
        @(posedge sys_clk);
        high_alarm_threshold <= 10'h200;
        low_alarm_threshold <= 10'h030;
        c = '0;
        c.samples_sel = 3'h2;
        run(c, '{10'h040, 10'h210});
        check("alarm average", result.average, 10'h010);
        check("flags", ack, 3'h2);
        strobe(2);
        run(c, '{10'h040, 10'h040, 10'h020});
        check("alarm average", result.average, 10'h020);
        check("flags", ack, 3'h1);
        strobe(2);
        @(posedge sys_clk);
        high_alarm_threshold <= 10'h300;
        low_alarm_threshold <= 10'h008;
        c.samples_sel = 3'h1;
        c.wait_sel = 4'h1;
        @(posedge sys_clk);
        cfg <= c;
        conv_u.push(10'h100);
        conv_u.push(10'h100);
        strobe(0);
        wait_on(2, 1'b1, 50, n);
        wait_on(1, 1'b1, 400, n);
        check("wait gap", n >= 245 && n <= 285, 1);
        wait_on(0, 1'b0, 50, n);
        strobe(2);
        for (int p = 0; p < 2; p++) begin
            @(posedge sys_clk);
            general_input_three <= !p[0];
            c = '0;
            c.ext_trig_en = 1'b1;
            c.trig_rising = p[0];
            @(posedge sys_clk);
            cfg <= c;
            repeat (4) @(posedge sys_clk);
            strobe(0);
            count_on(0, 4, k);
            check("busy", k, 0);
            conv_u.push(10'h0AA);
            @(posedge sys_clk);
            general_input_three <= p[0];
            wait_on(0, 1'b1, 8, n);
            wait_on(0, 1'b0, 200, n);
            check("flags", ack, 3'h4);
            strobe(2);
        end
        @(posedge sys_clk);
        general_input_three <= 1'b0;
        c.holdoff_en = 1'b1;
        c.samples_sel = 3'h1;
        c.wait_sel = 4'h1;
        @(posedge sys_clk);
        cfg <= c;
        conv_u.push(10'h100);
        conv_u.push(10'h200);
        repeat (3) @(posedge sys_clk);
        general_input_three <= 1'b1;
        wait_on(2, 1'b1, 50, n);
        @(posedge sys_clk);
        general_input_three <= 1'b0;
        count_on(1, 500, k);
        check("held requests", k, 0);
        @(posedge sys_clk);
        general_input_three <= 1'b1;
        wait_on(1, 1'b1, 40, n);
        wait_on(0, 1'b0, 50, n);
        check("average", result.average, 10'h180);
        strobe(2);
        // slow answers keep the stop inside an open conversion
        @(posedge sys_clk);
        c = '0;
        c.repeat_mode = 1'b1;
        cfg <= c;
        ack_delay <= 8'h08;
        conv_u.push(10'h111);
        conv_u.push(10'h122);
        strobe(0);
        wait_on(2, 1'b1, 50, n);
        wait_on(1, 1'b1, 26000, n);
        check("run delay", n >= 24995 && n <= 25060, 1);
        check("flags", ack, 3'h0);
        strobe(1);
        wait_on(0, 1'b0, 50, n);
        check("flags", ack, 3'h4);
        check("last", result.last, 10'h122);
        // stop while the inter-run delay runs
        strobe(2);
        conv_u.push(10'h133);
        strobe(0);
        wait_on(2, 1'b1, 50, n);
        repeat (4) @(posedge sys_clk);
        strobe(1);
        wait_on(0, 1'b0, 50, n);
        check("flags", ack, 3'h4);
        check("last", result.last, 10'h133);
        for (int b = 0; b < 16; b++) begin
            @(posedge sys_clk);
            fault_mask <= 16'(b[0]) << b;
            fault_in <= 16'h0001 << b;
            count_on(3, 4, k);
            check("fault pulses", k, !b[0]);
            @(posedge sys_clk);
            fault_in <= 16'h0000;
        end
        stop_test();
    end
endmodule : tb_acs_sequencer
